// File: design/timing_pkg.sv
// timing_pkg: constants, types and layouts shared by the timing generator
// assumes a single 125 MHz system clock and an APB register port
package timing_pkg;
  // clock and chain sizes
  localparam int CLK_MHZ = 125;
  localparam int PRE_BITS = 2;
  localparam int DIV_BITS = 21;
  localparam int CHAIN_BITS = PRE_BITS + DIV_BITS;
  localparam int LOW_BITS = PRE_BITS + 6;
  localparam int HI_BITS = CHAIN_BITS - LOW_BITS;
  localparam int MC_STATES = 4;
  localparam logic [3:0] INST_MIN = 4'h1;
  localparam logic [3:0] INST_MAX = 4'ha;
  // chain tap positions (index into prescaler plus divider)
  localparam int DVO_TAP = 12;
  localparam int TBT_TAP = 16;
  localparam int WDT_TAP = 20;
  localparam int TMR_TAP = 9;
  localparam int WARM_TAP = 14;
  // memory map
  localparam logic [15:0] SFR_LAST = 16'h003f;
  localparam logic [15:0] RAM_FIRST = 16'h0040;
  localparam logic [15:0] DIRECT_LAST = 16'h00ff;
  localparam logic [15:0] RAM_LAST = 16'h043f;
  localparam logic [15:0] ROM_FIRST = 16'h1000;
  localparam logic [15:0] ROM_LAST = 16'hffff;
  localparam int ROM_BYTES = 61440;
  localparam int RAM_BYTES = 1024;
  localparam int DIRECT_BYTES = 192;
  // register byte offsets
  localparam logic [7:0] OFS_SYS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TB_CTRL = 8'h04;
  localparam logic [7:0] OFS_STOP_CTRL = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_CHAIN = 8'h10;
  // field positions
  localparam int SYSTEM_CLOCK_SELECT_BIT = 0;
  localparam int XEN_BIT = 1;
  localparam int XTEN_BIT = 2;
  localparam int SLEEP_BIT = 3;
  localparam int DV7_BIT = 0;
  localparam int STOP_BIT = 0;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  // machine cycle states, one-hot
  typedef enum logic [3:0] {
    MC_S0 = 4'b0001,
    MC_S1 = 4'b0010,
    MC_S2 = 4'b0100,
    MC_S3 = 4'b1000
  } mc_state_e;
  // power sequencing, one-hot
  typedef enum logic [2:0] {
    PWR_RUN = 3'b001,
    PWR_STOP = 3'b010,
    PWR_WARM = 3'b100
  } power_e;
  // software controlled system bits
  typedef struct packed {
    logic sleep;
    logic low_freq_enable;
    logic high_freq_enable;
    logic system_clock_select;
  } sys_ctrl_s;
  localparam sys_ctrl_s SYS_CTRL_RESET = 4'h2;
  // divider derived clock pulses
  typedef struct packed {
    logic divider_output_pulse;
    logic time_base_src;
    logic watchdog_src;
    logic timer_src;
  } taps_s;
endpackage

// File: design/mem_map_decoder.sv
// mem_map_decoder: registered region selects for the 64 Kbyte space
// assumes the address comes from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module mem_map_decoder (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic [15:0] addr_i,
  output logic sfr_sel_o,
  output logic ram_sel_o,
  output logic direct_sel_o,
  output logic rom_sel_o
);
  // region compare, one flop per select
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sfr_sel_o <= 1'b0;
      ram_sel_o <= 1'b0;
      direct_sel_o <= 1'b0;
      rom_sel_o <= 1'b0;
    end else begin
      sfr_sel_o <= addr_i <= timing_pkg::SFR_LAST;
      ram_sel_o <= addr_i >= timing_pkg::RAM_FIRST &&
                   addr_i <= timing_pkg::RAM_LAST;
      direct_sel_o <= addr_i >= timing_pkg::RAM_FIRST &&
                      addr_i <= timing_pkg::DIRECT_LAST;
      rom_sel_o <= addr_i >= timing_pkg::ROM_FIRST;
    end
  end

  property p_rom_decode;
    @(posedge mclk_i) disable iff (!rst_b_i)
      rom_sel_o == ($past(addr_i) >= timing_pkg::ROM_FIRST);
  endproperty
  a_rom_decode: assert property (p_rom_decode)
    else $error("program region select wrong");

  property p_ram_decode;
    @(posedge mclk_i) disable iff (!rst_b_i)
      (addr_i >= timing_pkg::RAM_FIRST && addr_i <= timing_pkg::RAM_LAST)
      |=> ram_sel_o && !rom_sel_o && !sfr_sel_o;
  endproperty
  a_ram_decode: assert property (p_ram_decode)
    else $error("ram region select wrong");

  property p_direct_decode;
    @(posedge mclk_i) disable iff (!rst_b_i)
      direct_sel_o |-> ram_sel_o && $past(addr_i) <= timing_pkg::DIRECT_LAST;
  endproperty
  a_direct_decode: assert property (p_direct_decode)
    else $error("direct area select wrong");
endmodule
`default_nettype wire

// File: design/system_timing_generator.sv
// system_timing_generator: prescaler, divider, main clock and cycle states
// assumes APB from the same clock; low_freq_clock_i and the stop release
// pin are asynchronous and are synchronised here; mclk stands for fc
`timescale 1ns/1ps
`default_nettype none
module system_timing_generator #(
  parameter int WARM_TAP = timing_pkg::WARM_TAP
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic low_freq_clock_i,
  input wire logic stop_release_b_i,
  input wire logic [3:0] inst_cycles_i,
  input wire logic [15:0] mem_addr_i,
  output logic main_clk_en_o,
  output logic [3:0] machine_cycle_states_o,
  output logic cycle_end_o,
  output logic inst_done_o,
  output timing_pkg::taps_s taps_o,
  output logic cpu_halt_o,
  output logic low_clock_active_o,
  output logic warm_up_o,
  output logic sfr_sel_o,
  output logic ram_sel_o,
  output logic direct_sel_o,
  output logic rom_sel_o
);
  localparam int LB = timing_pkg::LOW_BITS;
  localparam int HB = timing_pkg::HI_BITS;

  timing_pkg::sys_ctrl_s sys_ctrl;
  logic seventh_stage_source_select;
  logic [LB-1:0] low_chain;
  logic [HB-1:0] hi_chain;
  logic [timing_pkg::CHAIN_BITS-1:0] chain, chain_prev;
  timing_pkg::mc_state_e mc_state;
  timing_pkg::power_e power;
  logic active_lf, stop_from_hf;
  logic [2:0] lf_sync;
  logic [1:0] rel_sync;
  logic [3:0] inst_left;
  logic fs_tick, fc_run, lf_mode, hf_stopped, low_tick, carry6;
  logic stage7_tick, main_tick, chain_clear, stop_go, warm_done;
  logic apb_done, apb_hit, wr_en;

  // clamps an instruction length into the legal span
  function automatic logic [3:0] clamp_len(input logic [3:0] n);
    if (n < timing_pkg::INST_MIN) begin
      clamp_len = timing_pkg::INST_MIN;
    end else if (n > timing_pkg::INST_MAX) begin
      clamp_len = timing_pkg::INST_MAX;
    end else begin
      clamp_len = n;
    end
  endfunction

  // true when the offset is one of the mapped registers
  function automatic logic mapped(input logic [7:0] a);
    mapped = a == timing_pkg::OFS_SYS_CTRL || a == timing_pkg::OFS_TB_CTRL ||
             a == timing_pkg::OFS_STOP_CTRL || a == timing_pkg::OFS_STATUS ||
             a == timing_pkg::OFS_CHAIN;
  endfunction

  // synchronisers for the low clock and the release pin
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lf_sync <= 3'h0;
      rel_sync <= 2'h3;
    end else begin
      lf_sync <= {lf_sync[1:0], low_freq_clock_i};
      rel_sync <= {rel_sync[0], stop_release_b_i};
    end
  end

  // clock enables and mode decode
  assign fs_tick = lf_sync[1] & ~lf_sync[2] & sys_ctrl.low_freq_enable &
                   power != timing_pkg::PWR_STOP;
  assign fc_run = sys_ctrl.high_freq_enable & power != timing_pkg::PWR_STOP;
  assign lf_mode = sys_ctrl.system_clock_select;
  assign hf_stopped = lf_mode & ~sys_ctrl.high_freq_enable;
  assign low_tick = fc_run & ~hf_stopped;
  assign carry6 = low_tick & (&low_chain);
  assign chain = {hi_chain, low_chain};

  // stage seven source choice
  always_comb begin
    if (power == timing_pkg::PWR_WARM && stop_from_hf) begin
      stage7_tick = carry6;
    // slow mode (system clock select) forces low clock
    end else if (lf_mode) begin
      stage7_tick = fs_tick;
    end else if (seventh_stage_source_select) begin
      stage7_tick = fs_tick;
    end else begin
      stage7_tick = carry6;
    end
  end

  // stop sequencing
  assign stop_go = wr_en && paddr_i == timing_pkg::OFS_STOP_CTRL &&
                   pwdata_i[timing_pkg::STOP_BIT];
  assign warm_done = power == timing_pkg::PWR_WARM && chain[WARM_TAP];
  assign chain_clear = (power == timing_pkg::PWR_RUN && stop_go) ||
                       (power == timing_pkg::PWR_STOP && !rel_sync[1]) ||
                       warm_done;

  // power state: run, stop, warm-up
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      power <= timing_pkg::PWR_RUN;
      stop_from_hf <= 1'b0;
    end else begin
      case (power)
        timing_pkg::PWR_RUN: begin
          if (stop_go) begin
            power <= timing_pkg::PWR_STOP;
            stop_from_hf <= ~lf_mode;
          end
        end
        timing_pkg::PWR_STOP: begin
          if (!rel_sync[1]) begin
            power <= timing_pkg::PWR_WARM;
          end
        end
        timing_pkg::PWR_WARM: begin
          if (warm_done) begin
            power <= timing_pkg::PWR_RUN;
          end
        end
        default: power <= timing_pkg::PWR_RUN;
      endcase
    end
  end

  // prescaler plus stages one-six
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      low_chain <= '0;
    // clear on stop entry and exit
    end else if (chain_clear) begin
      low_chain <= '0;
    end else if (low_tick) begin
      low_chain <= low_chain + 1'b1;
    end
  end

  // stages seven-twenty-one
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hi_chain <= '0;
    end else if (chain_clear) begin
      hi_chain <= '0;
    end else if (stage7_tick) begin
      hi_chain <= hi_chain + 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      chain_prev <= '0;
      taps_o <= '0;
    end else begin
      chain_prev <= chain;
      taps_o.divider_output_pulse <= chain[timing_pkg::DVO_TAP] &
                                     ~chain_prev[timing_pkg::DVO_TAP];
      taps_o.time_base_src <= chain[timing_pkg::TBT_TAP] &
                              ~chain_prev[timing_pkg::TBT_TAP];
      taps_o.watchdog_src <= chain[timing_pkg::WDT_TAP] &
                             ~chain_prev[timing_pkg::WDT_TAP];
      taps_o.timer_src <= chain[timing_pkg::TMR_TAP] &
                          ~chain_prev[timing_pkg::TMR_TAP];
    end
  end

  assign main_tick = power == timing_pkg::PWR_RUN &&
                     (active_lf ? fs_tick : fc_run);

  // machine cycle states and source switch
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mc_state <= timing_pkg::MC_S0;
      active_lf <= 1'b0;
    end else if (main_tick) begin
      case (mc_state)
        timing_pkg::MC_S0: mc_state <= timing_pkg::MC_S1;
        timing_pkg::MC_S1: mc_state <= timing_pkg::MC_S2;
        timing_pkg::MC_S2: mc_state <= timing_pkg::MC_S3;
        timing_pkg::MC_S3: begin
          mc_state <= timing_pkg::MC_S0;
          active_lf <= lf_mode;
        end
        default: mc_state <= timing_pkg::MC_S0;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      inst_left <= '0;
      inst_done_o <= 1'b0;
    end else begin
      inst_done_o <= 1'b0;
      if (main_tick && mc_state == timing_pkg::MC_S3) begin
        if (inst_left <= timing_pkg::INST_MIN) begin
          inst_done_o <= inst_left == timing_pkg::INST_MIN;
          inst_left <= inst_left == timing_pkg::INST_MIN ? 4'h0 : 
                       clamp_len(inst_cycles_i) - 1'b1;
          if (inst_left == 4'h0 && clamp_len(inst_cycles_i) ==
              timing_pkg::INST_MIN) begin
            inst_done_o <= 1'b1;
          end
        end else begin
          inst_left <= inst_left - 1'b1;
        end
      end
    end
  end

  // registered status outputs
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      main_clk_en_o <= 1'b0;
      machine_cycle_states_o <= timing_pkg::MC_S0;
      cycle_end_o <= 1'b0;
      cpu_halt_o <= 1'b0;
      low_clock_active_o <= 1'b0;
      warm_up_o <= 1'b0;
    end else begin
      main_clk_en_o <= main_tick;
      machine_cycle_states_o <= mc_state;
      cycle_end_o <= main_tick && mc_state == timing_pkg::MC_S3;
      cpu_halt_o <= sys_ctrl.sleep || power != timing_pkg::PWR_RUN;
      low_clock_active_o <= active_lf;
      warm_up_o <= power == timing_pkg::PWR_WARM;
    end
  end

  // apb slave, one wait state
  assign apb_hit = psel_i & penable_i;
  assign apb_done = apb_hit & pready_o;
  assign wr_en = apb_done & pwrite_i & mapped(paddr_i);
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= timing_pkg::WORD_ZERO;
    end else begin
      pready_o <= apb_hit & ~pready_o;
      pslverr_o <= apb_hit & ~pready_o & ~mapped(paddr_i);
      prdata_o <= timing_pkg::WORD_ZERO;
      if (apb_hit && !pready_o && !pwrite_i) begin
        case (paddr_i)
          timing_pkg::OFS_SYS_CTRL: prdata_o[3:0] <= sys_ctrl;
          timing_pkg::OFS_TB_CTRL:
            prdata_o[timing_pkg::DV7_BIT] <= seventh_stage_source_select;
          timing_pkg::OFS_STATUS: prdata_o[7:0] <= {active_lf, power, mc_state};
          timing_pkg::OFS_CHAIN:
            prdata_o[timing_pkg::CHAIN_BITS-1:0] <= chain;
          default: prdata_o <= timing_pkg::WORD_ZERO;
        endcase
      end
    end
  end

  // control registers
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sys_ctrl <= timing_pkg::SYS_CTRL_RESET;
      seventh_stage_source_select <= 1'b0;
    end else if (wr_en) begin
      if (paddr_i == timing_pkg::OFS_SYS_CTRL) begin
        sys_ctrl <= pwdata_i[3:0];
      end
      if (paddr_i == timing_pkg::OFS_TB_CTRL) begin
        seventh_stage_source_select <= pwdata_i[timing_pkg::DV7_BIT];
      end
    end
  end

  mem_map_decoder u_map (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .addr_i(mem_addr_i),
    .sfr_sel_o(sfr_sel_o),
    .ram_sel_o(ram_sel_o),
    .direct_sel_o(direct_sel_o),
    .rom_sel_o(rom_sel_o)
  );

  sequence s_stop_entry;
    power == timing_pkg::PWR_RUN && stop_go;
  endsequence
  property p_clear_stop;
    @(posedge mclk_i) disable iff (!rst_b_i)
      s_stop_entry |=> chain == '0 && power == timing_pkg::PWR_STOP;
  endproperty
  a_clear_stop: assert property (p_clear_stop)
    else $error("chain not cleared at stop entry");

  sequence s_cycle;
    main_tick && mc_state == timing_pkg::MC_S0;
  endsequence
  property p_state_order;
    @(posedge mclk_i) disable iff (!rst_b_i)
      s_cycle |=> mc_state == timing_pkg::MC_S1;
  endproperty
  a_state_order: assert property (p_state_order)
    else $error("state s0 not followed by s1");

  // fc-sourced cycle: s0 tick then three more ticks, the third one taken in s3
  property p_single_cycle;
    @(posedge mclk_i) disable iff (!rst_b_i)
      (s_cycle and (!active_lf && fc_run && !lf_mode)) ##1 main_tick [*3]
      |-> mc_state == timing_pkg::MC_S3;
  endproperty
  a_single_cycle: assert property (p_single_cycle)
    else $error("state walk broken in single clock");

  property p_lf_feed;
    @(posedge mclk_i) disable iff (!rst_b_i)
      (lf_mode && power == timing_pkg::PWR_RUN && fs_tick && !chain_clear)
      |=> hi_chain == $past(hi_chain) + 1'b1;
  endproperty
  a_lf_feed: assert property (p_lf_feed)
    else $error("low clock not fed to stage seven");

  property p_hf_halt;
    @(posedge mclk_i) disable iff (!rst_b_i)
      (hf_stopped && !chain_clear) |=> low_chain == $past(low_chain);
  endproperty
  a_hf_halt: assert property (p_hf_halt)
    else $error("stages one-six ran in low-only mode");

  property p_warm_feed;
    @(posedge mclk_i) disable iff (!rst_b_i)
      (power == timing_pkg::PWR_WARM && stop_from_hf && !chain_clear)
      |=> hi_chain == $past(hi_chain) + $past(carry6);
  endproperty
  a_warm_feed: assert property (p_warm_feed)
    else $error("warm-up did not use stage six");

  property p_switch_at_s3;
    @(posedge mclk_i) disable iff (!rst_b_i)
      active_lf != $past(active_lf) |-> $past(mc_state) == timing_pkg::MC_S3
      && mc_state == timing_pkg::MC_S0;
  endproperty
  a_switch_at_s3: assert property (p_switch_at_s3)
    else $error("clock source switched mid cycle");
endmodule
`default_nettype wire

// File: test/far_side_model.sv
// far_side_model: low-frequency oscillator pin and stop release pin
// assumes mclk_i is the system clock; fs toggles only while enabled
`timescale 1ns/1ps
`default_nettype none
module far_side_model #(
  parameter int HALF = 5
) (
  input wire logic mclk_i,
  input wire logic osc_on_i,
  input wire logic release_i,
  output logic low_freq_clock_o,
  output logic stop_release_b_o
);
  int cnt = 0;
  initial low_freq_clock_o = 1'b0;
  // oscillator: low and still while off, steady square wave while on
  always @(posedge mclk_i) begin
    if (!osc_on_i) begin
      cnt <= 0;
      low_freq_clock_o <= 1'b0;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      low_freq_clock_o <= !low_freq_clock_o;
    end else begin
      cnt <= cnt + 1;
    end
  end
  // release pin is active low
  assign stop_release_b_o = !release_i;
endmodule
`default_nettype wire

// File: test/system_timing_generator_tb.sv
// system_timing_generator_tb: self-checking bench for the timing block
// assumes timing_pkg, the design and far_side_model are compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) check(32'(a), 32'(b))
module system_timing_generator_tb;
  logic mclk_i = 1'b0, rst_b_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0;
  logic pwrite_i = 1'b0, fs_on = 1'b0, rel = 1'b0, err;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
  logic [3:0] inst_cycles_i = 4'h1, machine_cycle_states_o;
  logic [15:0] mem_addr_i = 16'h0;
  logic pready_o, pslverr_o, low_freq_clock_i, stop_release_b_i;
  logic main_clk_en_o, cycle_end_o, inst_done_o, cpu_halt_o, warm_up_o;
  logic low_clock_active_o, sfr_sel_o, ram_sel_o, direct_sel_o, rom_sel_o;
  timing_pkg::taps_s taps_o;
  int fail_count = 0, tests_run = 0, n, g;
  logic [15:0] edges[9] = '{16'h003f, 16'h0040, 16'h00ff, 16'h0100,
    16'h043f, 16'h0440, 16'h0fff, 16'h1000, 16'hffff};
  int lens[5] = '{0, 1, 5, 10, 12};

  system_timing_generator #(.WARM_TAP(8)) dut (.mclk_i, .rst_b_i,
    .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
    .pready_o, .pslverr_o, .low_freq_clock_i, .stop_release_b_i,
    .inst_cycles_i, .mem_addr_i, .main_clk_en_o, .machine_cycle_states_o,
    .cycle_end_o, .inst_done_o, .taps_o, .cpu_halt_o, .low_clock_active_o,
    .warm_up_o, .sfr_sel_o, .ram_sel_o, .direct_sel_o, .rom_sel_o);
  far_side_model #(.HALF(5)) far (.mclk_i(mclk_i), .osc_on_i(fs_on),
    .release_i(rel), .low_freq_clock_o(low_freq_clock_i),
    .stop_release_b_o(stop_release_b_i));

  always #4 mclk_i = ~mclk_i;

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // apb transfer: hold request until pready_o is sampled high
  task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
    int k;
    k = 0;
    @(posedge mclk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge mclk_i);
      k++;
    end while (pready_o !== 1'b1 && k < 50);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  // edges from one pulse of a signal to the next: taps, main, done
  task automatic gap(input int b, output int gg);
    logic s;
    repeat (2) begin
      gg = 0;
      do begin
        @(posedge mclk_i);
        gg++;
        s = b < 4 ? taps_o[b] : (b == 4 ? main_clk_en_o : inst_done_o);
      end while (s !== 1'b1 && gg < 20000);
    end
  endtask

  // reference region decode {sfr, ram, direct, rom}
  function automatic logic [3:0] dec(input logic [15:0] a);
    return {a <= 16'h003f, a >= 16'h0040 && a <= 16'h043f,
      a >= 16'h0040 && a <= 16'h00ff, a >= 16'h1000};
  endfunction

  initial begin
    n = $urandom(32'h345a);
    repeat (10) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    // register reset values, unmapped place
    apb(1'b0, timing_pkg::OFS_SYS_CTRL, 32'h0);
    `CHK(rd, 32'h2);
    apb(1'b0, timing_pkg::OFS_STATUS, 32'h0);
    `CHK(rd[7:4], 4'h1);
    apb(1'b0, 8'h14, 32'h0);
    `CHK({err, rd[30:0]}, 32'h8000_0000);
    for (n = 0; n < 8 && machine_cycle_states_o !== 4'h1; n++)
      @(posedge mclk_i);
    for (n = 1; n < 9; n++) begin
      @(posedge mclk_i);
      `CHK(machine_cycle_states_o, 4'h1 << (n % 4));
      `CHK(main_clk_en_o, 1'b1);
    end
    for (n = 0; n < 40; n++) begin
      mem_addr_i <= n < 9 ? edges[n] : 16'($urandom());
      repeat (2) @(posedge mclk_i);
      `CHK({sfr_sel_o, ram_sel_o, direct_sel_o, rom_sel_o},
        dec(mem_addr_i));
    end
    gap(0, g);
    `CHK(g, 1024);
    gap(3, g);
    `CHK(g, 8192);
    for (n = 0; n < 5; n++) begin
      inst_cycles_i <= 4'(lens[n]);
      gap(5, g);
      `CHK(g, 4 * (lens[n] < 1 ? 1 : lens[n] > 10 ? 10 : lens[n]));
    end
    // dual clock first, select only after fs is steady
    apb(1'b1, timing_pkg::OFS_SYS_CTRL, 32'h6);
    fs_on <= 1'b1;
    repeat (40) @(posedge mclk_i);
    apb(1'b1, timing_pkg::OFS_TB_CTRL, 32'h1);
    gap(0, g);
    `CHK(g, 40);
    // run from fs, one main tick per fs period
    apb(1'b1, timing_pkg::OFS_SYS_CTRL, 32'h7);
    for (n = 0; n < 100 && low_clock_active_o !== 1'b1; n++)
      @(posedge mclk_i);
    `CHK(low_clock_active_o, 1'b1);
    gap(4, g);
    `CHK(g, 10);
    // fc off stops stages one to six
    apb(1'b1, timing_pkg::OFS_SYS_CTRL, 32'h5);
    apb(1'b0, timing_pkg::OFS_CHAIN, 32'h0);
    g = int'(rd[7:0]);
    repeat (30) @(posedge mclk_i);
    apb(1'b0, timing_pkg::OFS_CHAIN, 32'h0);
    `CHK(rd[7:0], g);
    apb(1'b1, timing_pkg::OFS_SYS_CTRL, 32'h6);
    for (n = 0; n < 100 && low_clock_active_o !== 1'b0; n++)
      @(posedge mclk_i);
    // stop from fc with seventh select still set
    apb(1'b1, timing_pkg::OFS_STOP_CTRL, 32'h1);
    apb(1'b0, timing_pkg::OFS_STATUS, 32'h0);
    `CHK(rd[6:4], 3'b010);
    apb(1'b0, timing_pkg::OFS_CHAIN, 32'h0);
    `CHK(rd, 32'h0);
    `CHK(cpu_halt_o, 1'b1);
    rel <= 1'b1;
    for (n = 0; n < 20 && warm_up_o !== 1'b1; n++) @(posedge mclk_i);
    rel <= 1'b0;
    for (g = 0; g < 400 && warm_up_o === 1'b1; g++) @(posedge mclk_i);
    `CHK(g >= 250 && g <= 260, 1'b1);
    apb(1'b0, timing_pkg::OFS_CHAIN, 32'h0);
    // stage seven may already have taken one fs tick since the clear
    `CHK(rd[7:0] < 8'h20 && rd[22:8] < 15'h2, 1'b1);
    close_out();
  end

  // watchdog well beyond the expected run length
  initial begin
    repeat (60000) @(posedge mclk_i);
    fail_count++;
    close_out();
  end
endmodule
`default_nettype wire
